// ===== src/bpsw_regs.svh
`ifndef BPSW_REGS_SVH
`define BPSW_REGS_SVH

// register byte offsets
`define BPSW_ADDR_W       4
`define BPSW_OFS_CTRL     4'h0
`define BPSW_OFS_STATUS   4'h4
`define BPSW_OFS_ASTAT    4'h8

// control fields
`define BPSW_CTRL_SLP     0
`define BPSW_CTRL_WATCHDOG_ENABLE    1
`define BPSW_CTRL_WDT_LSB 4
`define BPSW_CTRL_WDT_MSB 7

// status fields
`define BPSW_ST_STATE_LSB 0
`define BPSW_ST_STATE_MSB 2
`define BPSW_ST_TW        3
`define BPSW_ST_BUS       4
`define BPSW_ST_FILT      5
`define BPSW_ST_ADJ       6
`define BPSW_ST_V20       7
`define BPSW_ST_OSC       8
`define BPSW_ST_CLK_LSB   9
`define BPSW_ST_CLK_MSB   10

// latched status fields
`define BPSW_AS_TSD       0
`define BPSW_AS_SLPX      1

// axi responses
`define BPSW_RESP_OKAY    2'h0
`define BPSW_RESP_SLVERR  2'h2

// times in ms, clock in kHz (cycles per ms)
`define BPSW_CLK_KHZ      20000
`define BPSW_SAVE_DLY_MS  2
`define BPSW_OSC_DLY_MS   2
`define BPSW_BUS_FILT_MS  1
`define BPSW_WD_RST_MS    1

// watchdog table, code 15 first, 10 bits per entry
`define BPSW_WD_TMO_MS {10'd524, 10'd492, 10'd459, 10'd426, 10'd393, 10'd360, 10'd328, \
	10'd295, 10'd262, 10'd229, 10'd197, 10'd164, 10'd131, 10'd98, 10'd66, 10'd33}
`define BPSW_WD_EARLY_MS {10'd31, 10'd30, 10'd29, 10'd27, 10'd25, 10'd23, 10'd20, \
	10'd18, 10'd16, 10'd14, 10'd12, 10'd10, 10'd8, 10'd6, 10'd4, 10'd2}
`define BPSW_WD_MS_W      10

`endif

// ===== src/bpsw_pkg.sv
package bpsw_pkg;

	// gray along reset, start-up, stand-by, normal, sleep
	typedef enum logic [2:0]
	{
		BPSW_RESET   = 3'h0,
		BPSW_STARTUP = 3'h1,
		BPSW_STANDBY = 3'h3,
		BPSW_NORMAL  = 3'h2,
		BPSW_SLEEP   = 3'h6
	} bpsw_state_t;

	typedef enum logic [1:0]
	{
		BPSW_CLK_OFF = 2'h0,
		BPSW_CLK_4M  = 2'h1,
		BPSW_CLK_8M  = 2'h2
	} bpsw_clk_t;

endpackage

// ===== src/bpsw_top.sv
// What this block does
// - save warning low at once on filter under 14 V, or bus under 20 V for 2 ms.
// - host reset low whenever filter voltage is below 12 V.
// - thermal warning pulls save warning low and sets a readable warning bit.
// - thermal shutdown forces Reset, latches a flag, stops supplies, holds while hot.
// - after cooling go Start-Up, then Stand-By with reset released and oscillator started.
// - warning bit clears by itself once temperature is under warning level.
// - shutdown flag clears only when cool and the host has read it.
// - sleep request enters Sleep; only wake, thermal shutdown or power-on leaves; exit bit readable.
// - sleep requests are ignored while the wake input is low.
// - watchdog stays inactive until host writes one to its enable bit.
// - early or missing watchdog refresh pulls host reset low.
// - 4-bit code selects timeout and early limit, 33/2 ms up to 524/31 ms.
// - in Reset, filter at 10 V enables fixed converter and enters Start-Up.
// - in Start-Up, fixed supply above 2.8 V reads trim, then Stand-By, reset high.
// - on Stand-By entry set bus bit if bus high; oscillator starts 2 ms later.
// - adjustable converter and 20 V regulator start only with filter above high level.
// - Normal and save release need oscillator, no thermal flags, all supply bits.
// - bus below low level past filter time clears bus bit, Stand-By, save low.
// - filter below low level switches off adjustable converter and 20 V regulator.
// - filter under 6.5 V stops fixed converter; fixed supply loss with that converter stopped enters Reset.
// - clock out off in Start-Up, 4 MHz on Stand-By entry from Start-Up, 8 MHz in Normal, 4 MHz after oscillator fault in Normal.
// - in Sleep a low wake input starts the power-up procedure.
`include "bpsw_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module bpsw_top
#(
	parameter int unsigned MS_CYCLES = `BPSW_CLK_KHZ
)
(
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic [`BPSW_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	input  wire logic [`BPSW_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	input  wire logic                     filter_above_14v,
	input  wire logic                     filter_above_12v,
	input  wire logic                     filter_above_10v,
	input  wire logic                     filter_above_6v5,
	input  wire logic                     filter_high_threshold,
	input  wire logic                     filter_low_threshold,
	input  wire logic                     bus_high_threshold,
	input  wire logic                     bus_low_threshold,
	input  wire logic                     bus_above_20v,
	input  wire logic                     fixed_supply,
	input  wire logic                     adjustable_supply_ok,
	input  wire logic                     twenty_volt_reg_ok,
	input  wire logic                     temp_warning,
	input  wire logic                     temp_shutdown,
	input  wire logic                     osc_running,
	input  wire logic                     trim_done,
	input  wire logic                     wake_current_select,
	output logic                          host_reset_n_out,
	output logic                          host_reset_n_oe_n,
	output logic                          save_warning_n_out,
	output logic                          save_warning_n_oe_n,
	output logic                          fixed_converter_en,
	output logic                          adjustable_converter_en,
	output logic                          twenty_volt_reg_en,
	output logic                          osc_en,
	output logic                          trim_read,
	output logic [1:0]                    host_clock_out_sel
);

	localparam int unsigned SAVE_CYC = `BPSW_SAVE_DLY_MS * MS_CYCLES;
	localparam int unsigned OSC_CYC  = `BPSW_OSC_DLY_MS * MS_CYCLES;
	localparam int unsigned BUSF_CYC = `BPSW_BUS_FILT_MS * MS_CYCLES;
	localparam int unsigned WDR_CYC  = `BPSW_WD_RST_MS * MS_CYCLES;
	localparam int          NSYNC    = 17;

	// ms figure times cycles per ms, for either column of the table
	function automatic logic [31:0] wd_cycles(input logic [3:0] sel, input logic early);
		logic [16*`BPSW_WD_MS_W-1:0] tbl;
		logic [`BPSW_WD_MS_W-1:0]    ms;
		tbl = early ? `BPSW_WD_EARLY_MS : `BPSW_WD_TMO_MS;
		ms  = tbl[sel*`BPSW_WD_MS_W +: `BPSW_WD_MS_W];
		return 32'(ms) * MS_CYCLES;
	endfunction

	// ---- pin synchronisers ----
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic f14, f12, f10, f6v5, f_hi, f_lo, b_hi, b_lo, b20;
	logic fix_ok, adj_ok, v20_ok, tw, thermal_shutdown_flag, osc_ok, trim_ok, wake;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= {filter_above_14v, filter_above_12v, filter_above_10v,
				filter_above_6v5, filter_high_threshold, filter_low_threshold,
				bus_high_threshold, bus_low_threshold, bus_above_20v, fixed_supply,
				adjustable_supply_ok, twenty_volt_reg_ok, temp_warning, temp_shutdown,
				osc_running, trim_done, wake_current_select};
			sync2_q <= sync1_q;
		end
	end

	assign {f14, f12, f10, f6v5, f_hi, f_lo, b_hi, b_lo, b20, fix_ok, adj_ok, v20_ok,
		tw, thermal_shutdown_flag, osc_ok, trim_ok, wake} = sync2_q;

	// ---- axi4-lite slave ----
	logic                    aw_got_q;
	logic                    w_got_q;
	logic [`BPSW_ADDR_W-1:0] awaddr_q;
	logic [31:0]             wdata_q;
	logic                    wstrb0_q;
	logic                    wr_fire;
	logic                    ctrl_wr;
	logic                    ar_fire;
	logic                    astat_rd;
	logic [31:0]             rd_word;
	logic                    rd_hit;

	assign wr_fire  = aw_got_q && w_got_q && !s_axi_bvalid;
	assign ctrl_wr  = wr_fire && awaddr_q == `BPSW_OFS_CTRL && wstrb0_q;
	assign ar_fire  = s_axi_arvalid && s_axi_arready;
	assign astat_rd = ar_fire && s_axi_araddr == `BPSW_OFS_ASTAT;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `BPSW_RESP_OKAY;
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb0_q      <= 1'b0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				s_axi_awready <= 1'b0;
				aw_got_q      <= 1'b1;
				awaddr_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				s_axi_wready <= 1'b0;
				w_got_q      <= 1'b1;
				wdata_q      <= s_axi_wdata;
				wstrb0_q     <= s_axi_wstrb[0];
			end
			if (wr_fire)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == `BPSW_OFS_CTRL) ? `BPSW_RESP_OKAY
					: `BPSW_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ---- control register ----
	logic       sleep_req_q;
	logic       wd_en_q;
	logic [3:0] wd_sel_q;
	logic [31:0] wd_cnt_q;
	logic [31:0] wd_rst_cnt_q;
	logic        wd_fault;

	bpsw_pkg::bpsw_state_t state_q;
	bpsw_pkg::bpsw_state_t state_d;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sleep_req_q <= 1'b0;
		else if (state_d == bpsw_pkg::BPSW_SLEEP)
			sleep_req_q <= 1'b0;
		else if (ctrl_wr && wake)
			sleep_req_q <= wdata_q[`BPSW_CTRL_SLP];
		else if (ctrl_wr)
			sleep_req_q <= 1'b0;
	end

	// ---- watchdog ----
	assign wd_fault = wd_en_q &&
		((ctrl_wr && wdata_q[`BPSW_CTRL_WATCHDOG_ENABLE] && wd_cnt_q < wd_cycles(wd_sel_q, 1'b1))
		|| wd_cnt_q >= wd_cycles(wd_sel_q, 1'b0));

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wd_en_q      <= 1'b0;
			wd_sel_q     <= '0;
			wd_cnt_q     <= '0;
			wd_rst_cnt_q <= '0;
		end
		else
		begin
			if (wd_fault)
			begin
				// host restarts after the pulse, so it must re-arm explicitly
				wd_en_q      <= 1'b0;
				wd_cnt_q     <= '0;
				wd_rst_cnt_q <= WDR_CYC;
			end
			else if (ctrl_wr)
			begin
				wd_en_q  <= wdata_q[`BPSW_CTRL_WATCHDOG_ENABLE];
				wd_sel_q <= wdata_q[`BPSW_CTRL_WDT_MSB:`BPSW_CTRL_WDT_LSB];
				wd_cnt_q <= '0;
			end
			else if (wd_en_q)
				wd_cnt_q <= wd_cnt_q + 32'h1;
			if (!wd_fault && wd_rst_cnt_q != '0)
				wd_rst_cnt_q <= wd_rst_cnt_q - 32'h1;
		end
	end

	// ---- supply status and timers ----
	logic        tw_q;
	logic        tsd_flag_q;
	logic        slp_exit_q;
	logic        bus_st_q;
	logic        filt_st_q;
	logic        fix_en_q;
	logic [31:0] bus_lo_cnt_q;
	logic [31:0] b20_cnt_q;
	logic [31:0] osc_cnt_q;
	logic        bus_lo_exp;
	logic        b20_exp;
	logic        normal_ok;
	logic        active;

	assign bus_lo_exp = bus_lo_cnt_q >= BUSF_CYC;
	assign b20_exp    = b20_cnt_q >= SAVE_CYC;
	assign active     = state_q == bpsw_pkg::BPSW_STANDBY || state_q == bpsw_pkg::BPSW_NORMAL;
	assign normal_ok  = osc_ok && !tw && !tsd_flag_q && bus_st_q && filt_st_q
		&& adj_ok && v20_ok;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_lo_cnt_q <= '0;
			b20_cnt_q    <= '0;
		end
		else
		begin
			bus_lo_cnt_q <= b_lo ? '0 : (bus_lo_exp ? bus_lo_cnt_q : bus_lo_cnt_q + 32'h1);
			b20_cnt_q    <= b20 ? '0 : (b20_exp ? b20_cnt_q : b20_cnt_q + 32'h1);
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tw_q <= 1'b0;
		else
			tw_q <= tw;
	end

	// set wins over the read that would clear it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			tsd_flag_q <= 1'b0;
		else if (thermal_shutdown_flag)
			tsd_flag_q <= 1'b1;
		else if (astat_rd)
			tsd_flag_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			slp_exit_q <= 1'b0;
		else if (state_q == bpsw_pkg::BPSW_SLEEP && state_d != bpsw_pkg::BPSW_SLEEP)
			slp_exit_q <= 1'b1;
		else if (astat_rd)
			slp_exit_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bus_st_q <= 1'b0;
		else if (!active || bus_lo_exp)
			bus_st_q <= 1'b0;
		else if (b_hi)
			bus_st_q <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			filt_st_q <= 1'b0;
		else if (!f_lo)
			filt_st_q <= 1'b0;
		else if (f_hi)
			filt_st_q <= 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fix_en_q <= 1'b0;
		else if (state_d == bpsw_pkg::BPSW_RESET || state_d == bpsw_pkg::BPSW_SLEEP)
			fix_en_q <= 1'b0;
		else if (state_q == bpsw_pkg::BPSW_RESET)
			fix_en_q <= 1'b1;
		else if (!f6v5)
			fix_en_q <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			osc_cnt_q <= '0;
		else if (!active)
			osc_cnt_q <= '0;
		else if (osc_cnt_q < OSC_CYC)
			osc_cnt_q <= osc_cnt_q + 32'h1;
	end

	// ---- power state machine ----
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			bpsw_pkg::BPSW_RESET:
				if (!thermal_shutdown_flag && f10)
					state_d = bpsw_pkg::BPSW_STARTUP;
			bpsw_pkg::BPSW_STARTUP:
				if (fix_ok && trim_ok)
					state_d = bpsw_pkg::BPSW_STANDBY;
			bpsw_pkg::BPSW_STANDBY:
				if (sleep_req_q && wake)
					state_d = bpsw_pkg::BPSW_SLEEP;
				else if (normal_ok)
					state_d = bpsw_pkg::BPSW_NORMAL;
			bpsw_pkg::BPSW_NORMAL:
				if (sleep_req_q && wake)
					state_d = bpsw_pkg::BPSW_SLEEP;
				else if (!normal_ok)
					state_d = bpsw_pkg::BPSW_STANDBY;
			bpsw_pkg::BPSW_SLEEP:
				if (!wake)
					state_d = bpsw_pkg::BPSW_RESET;
			default:
				state_d = bpsw_pkg::BPSW_RESET;
		endcase
		if (thermal_shutdown_flag)
			state_d = bpsw_pkg::BPSW_RESET;
		if (state_q != bpsw_pkg::BPSW_RESET && state_q != bpsw_pkg::BPSW_SLEEP
			&& !fix_en_q && !fix_ok)
			state_d = bpsw_pkg::BPSW_RESET;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_q <= bpsw_pkg::BPSW_RESET;
		else
			state_q <= state_d;
	end

	// ---- outputs ----
	logic rst_low;
	logic save_low;

	assign rst_low = state_q == bpsw_pkg::BPSW_RESET || state_q == bpsw_pkg::BPSW_STARTUP
		|| state_q == bpsw_pkg::BPSW_SLEEP
		|| !f12
		|| wd_rst_cnt_q != '0;
	assign save_low = !f14 || b20_exp
		|| tw
		|| state_q != bpsw_pkg::BPSW_NORMAL;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			host_reset_n_out    <= 1'b0;
			save_warning_n_out  <= 1'b0;
			host_reset_n_oe_n   <= 1'b0;
			save_warning_n_oe_n <= 1'b0;
		end
		else
		begin
			host_reset_n_oe_n   <= !rst_low;
			save_warning_n_oe_n <= !save_low;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fixed_converter_en      <= 1'b0;
			adjustable_converter_en <= 1'b0;
			twenty_volt_reg_en      <= 1'b0;
			osc_en                  <= 1'b0;
			trim_read               <= 1'b0;
		end
		else
		begin
			fixed_converter_en      <= fix_en_q;
			adjustable_converter_en <= active && filt_st_q;
			twenty_volt_reg_en      <= active && filt_st_q;
			osc_en                  <= active && osc_cnt_q >= OSC_CYC;
			trim_read               <= state_q == bpsw_pkg::BPSW_STARTUP && fix_ok;
		end
	end

	// fault fallback only from Normal; otherwise Stand-By keeps its rate
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			host_clock_out_sel <= bpsw_pkg::BPSW_CLK_OFF;
		else if (state_d == bpsw_pkg::BPSW_NORMAL)
			host_clock_out_sel <= bpsw_pkg::BPSW_CLK_8M;
		else if (state_d != bpsw_pkg::BPSW_STANDBY)
			host_clock_out_sel <= bpsw_pkg::BPSW_CLK_OFF;
		else if (state_q == bpsw_pkg::BPSW_STARTUP)
			host_clock_out_sel <= bpsw_pkg::BPSW_CLK_4M;
		else if (state_q == bpsw_pkg::BPSW_NORMAL && !osc_ok)
			host_clock_out_sel <= bpsw_pkg::BPSW_CLK_4M;
	end

	// ---- read side ----
	always_comb
	begin
		rd_word = '0;
		rd_hit  = 1'b1;
		case (s_axi_araddr)
			`BPSW_OFS_CTRL:
			begin
				rd_word[`BPSW_CTRL_SLP]  = sleep_req_q;
				rd_word[`BPSW_CTRL_WATCHDOG_ENABLE] = wd_en_q;
				rd_word[`BPSW_CTRL_WDT_MSB:`BPSW_CTRL_WDT_LSB] = wd_sel_q;
			end
			`BPSW_OFS_STATUS:
			begin
				rd_word[`BPSW_ST_STATE_MSB:`BPSW_ST_STATE_LSB] = state_q;
				rd_word[`BPSW_ST_TW]  = tw_q;
				rd_word[`BPSW_ST_BUS] = bus_st_q;
				rd_word[`BPSW_ST_FILT] = filt_st_q;
				rd_word[`BPSW_ST_ADJ] = adj_ok;
				rd_word[`BPSW_ST_V20] = v20_ok;
				rd_word[`BPSW_ST_OSC] = osc_ok;
				rd_word[`BPSW_ST_CLK_MSB:`BPSW_ST_CLK_LSB] = host_clock_out_sel;
			end
			`BPSW_OFS_ASTAT:
			begin
				rd_word[`BPSW_AS_TSD]  = tsd_flag_q;
				rd_word[`BPSW_AS_SLPX] = slp_exit_q;
			end
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `BPSW_RESP_OKAY;
		end
		else if (ar_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? `BPSW_RESP_OKAY : `BPSW_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// ===== testbench/bpsw_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bpsw_top_assertions
#(
	parameter int unsigned MS_CYCLES = 4
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic filter_above_14v,
	input wire logic filter_above_12v,
	input wire logic filter_above_6v5,
	input wire logic filter_high_threshold,
	input wire logic filter_low_threshold,
	input wire logic bus_low_threshold,
	input wire logic bus_above_20v,
	input wire logic temp_warning,
	input wire logic temp_shutdown,
	input wire logic host_reset_n_oe_n,
	input wire logic save_warning_n_oe_n,
	input wire logic fixed_converter_en,
	input wire logic adjustable_converter_en,
	input wire logic twenty_volt_reg_en,
	input wire logic osc_en
);
	// sync flops and output flop, plus slack
	localparam int unsigned LIM = 2 * MS_CYCLES + 6;
	int unsigned b20_q;
	int unsigned blo_q;
	logic [3:0]  hi_age_q;

	always_ff @(posedge aclk)
	begin
		if (!aresetn || bus_above_20v)
			b20_q <= '0;
		else if (b20_q <= LIM)
			b20_q <= b20_q + 1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || bus_low_threshold)
			blo_q <= '0;
		else if (blo_q <= LIM)
			blo_q <= blo_q + 1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hi_age_q <= 4'hF;
		else if (filter_high_threshold)
			hi_age_q <= 4'h0;
		else if (hi_age_q != 4'hF)
			hi_age_q <= hi_age_q + 4'h1;
	end

	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_f12_lo;
		!filter_above_12v [*6];
	endsequence
	sequence s_hot;
		temp_shutdown [*6];
	endsequence

	property p_save_14v;
		!filter_above_14v [*6] |-> !save_warning_n_oe_n;
	endproperty
	a_save_14v: assert property (p_save_14v) else $error("save line free under 14 V");
	property p_save_bus;
		b20_q > LIM |-> !save_warning_n_oe_n;
	endproperty
	a_save_bus: assert property (p_save_bus) else $error("save line free on bus loss");
	property p_rst_12v;
		s_f12_lo |-> !host_reset_n_oe_n;
	endproperty
	a_rst_12v: assert property (p_rst_12v) else $error("host reset free under 12 V");
	property p_save_tw;
		temp_warning [*6] |-> !save_warning_n_oe_n;
	endproperty
	a_save_tw: assert property (p_save_tw) else $error("save line free while warm");
	property p_tsd;
		s_hot |-> !fixed_converter_en && !adjustable_converter_en && !host_reset_n_oe_n;
	endproperty
	a_tsd: assert property (p_tsd) else $error("supplies on while hot");
	property p_osc;
		$rose(osc_en) |-> host_reset_n_oe_n;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator started in reset");
	property p_adj_on;
		$rose(adjustable_converter_en) || $rose(twenty_volt_reg_en) |-> hi_age_q < 4'h8;
	endproperty
	a_adj_on: assert property (p_adj_on) else $error("converter on without high filter");
	property p_normal;
		$rose(save_warning_n_oe_n) |-> osc_en && adjustable_converter_en && twenty_volt_reg_en;
	endproperty
	a_normal: assert property (p_normal) else $error("save released too early");
	property p_bus_lo;
		blo_q > LIM |-> ##[0:4] !save_warning_n_oe_n;
	endproperty
	a_bus_lo: assert property (p_bus_lo) else $error("save line free, bus low");
	property p_adj_off;
		!filter_low_threshold [*6] |-> !adjustable_converter_en && !twenty_volt_reg_en;
	endproperty
	a_adj_off: assert property (p_adj_off) else $error("converter on, filter low");
	property p_fix_off;
		!filter_above_6v5 [*6] |-> !fixed_converter_en;
	endproperty
	a_fix_off: assert property (p_fix_off) else $error("fixed converter on, filter low");
endmodule

bind bpsw_top bpsw_top_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.*);
`default_nettype wire

// ===== testbench/bpsw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bpsw_host_model
(
	input  wire logic host_reset_n_out,
	input  wire logic host_reset_n_oe_n,
	input  wire logic save_warning_n_out,
	input  wire logic save_warning_n_oe_n,
	output logic      host_reset_n,
	output logic      save_warning_n,
	output int        reset_falls
);
	// pull-ups: a released line reads high
	assign host_reset_n = host_reset_n_oe_n ? 1'b1 : host_reset_n_out;
	assign save_warning_n = save_warning_n_oe_n ? 1'b1 : save_warning_n_out;

	initial
		reset_falls = 0;
	always @(negedge host_reset_n)
		reset_falls++;
endmodule
`default_nettype wire

// ===== testbench/test_bus_power_supervisor_watchdog.sv
`include "bpsw_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_bus_power_supervisor_watchdog;
	localparam int unsigned MS = 4;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, osc_ok, host_reset_n, save_warning_n;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [1:0]  s_axi_bresp, s_axi_rresp, host_clock_out_sel;
	logic        filter_above_14v, filter_above_12v, filter_above_10v, filter_above_6v5;
	logic        filter_high_threshold, filter_low_threshold, bus_high_threshold;
	logic        bus_low_threshold, bus_above_20v, fixed_supply, adjustable_supply_ok;
	logic        twenty_volt_reg_ok, temp_warning, temp_shutdown, osc_running, trim_done;
	logic        wake_current_select, host_reset_n_out, host_reset_n_oe_n;
	logic        save_warning_n_out, save_warning_n_oe_n, fixed_converter_en;
	logic        adjustable_converter_en, twenty_volt_reg_en, osc_en, trim_read;
	int          fail_count, checks_done, reset_falls;
	int          early[16] = '{2, 4, 6, 8, 10, 12, 14, 16, 18, 20, 23, 25, 27, 29, 30, 31};

	bpsw_top #(.MS_CYCLES(MS)) dut (.*);
	bpsw_host_model host (.*);

	initial
	begin
		aclk = 1'b0;
		forever
			#25 aclk = ~aclk;
	end

	// crystal follows its enable unless a fault is staged
	always @(posedge aclk)
		osc_running <= osc_en & osc_ok;

	task automatic print_verdict;
		$display("checks %0d, errors %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		chk(s_axi_bvalid, 1'b1);
		chk(s_axi_bresp, e);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] q, input logic [1:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		q = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk(s_axi_rvalid, 1'b1);
		chk(s_axi_rresp, e);
	endtask

	task automatic st_wait(input logic [2:0] s);
		int n;
		n = 0;
		do
		begin
			rd(`BPSW_OFS_STATUS, d, 2'h0);
			n++;
		end
		while (d[2:0] !== s && n < 100);
		chk(d[2:0], s);
	endtask

	task automatic up;
		{filter_above_14v, filter_above_12v, filter_above_10v, filter_above_6v5} <= 4'hF;
		{bus_high_threshold, bus_low_threshold, bus_above_20v} <= 3'h7;
		st_wait(bpsw_pkg::BPSW_STARTUP);
		chk(fixed_converter_en, 1'b1);
		chk(host_reset_n, 1'b0);
		fixed_supply <= 1'b1;
		cyc(6);
		chk(trim_read, 1'b1);
		trim_done <= 1'b1;
		st_wait(bpsw_pkg::BPSW_STANDBY);
		rd(`BPSW_OFS_STATUS, d, 2'h0);
		chk({d[10:9], d[4]}, 3'h3);
		chk(host_reset_n, 1'b1);
		chk(adjustable_converter_en, 1'b0);
		cyc(2 * MS + 4);
		chk(osc_en, 1'b1);
		{filter_high_threshold, filter_low_threshold} <= 2'h3;
		{adjustable_supply_ok, twenty_volt_reg_ok} <= 2'h3;
		st_wait(bpsw_pkg::BPSW_NORMAL);
		chk(d[10:4], 7'h5F);
		chk({save_warning_n, twenty_volt_reg_en}, 2'h3);
	endtask

	task automatic off;
		{filter_high_threshold, filter_low_threshold, filter_above_14v, filter_above_12v,
			filter_above_10v, filter_above_6v5, fixed_supply, bus_high_threshold,
			bus_low_threshold, bus_above_20v, trim_done, adjustable_supply_ok,
			twenty_volt_reg_ok} <= '0;
	endtask

	task automatic t_standby;
		{bus_high_threshold, bus_low_threshold, bus_above_20v} <= 3'h0;
		st_wait(bpsw_pkg::BPSW_STANDBY);
		chk({d[10:9], d[4], save_warning_n}, 4'h8);
		{bus_high_threshold, bus_low_threshold, bus_above_20v} <= 3'h7;
		st_wait(bpsw_pkg::BPSW_NORMAL);
		osc_ok <= 1'b0;
		st_wait(bpsw_pkg::BPSW_STANDBY);
		chk(d[10:9], 2'h1);
		osc_ok <= 1'b1;
		st_wait(bpsw_pkg::BPSW_NORMAL);
	endtask

	task automatic t_therm;
		temp_warning <= 1'b1;
		cyc(6);
		rd(`BPSW_OFS_STATUS, d, 2'h0);
		chk({d[3], save_warning_n}, 2'h2);
		temp_warning <= 1'b0;
		cyc(6);
		rd(`BPSW_OFS_STATUS, d, 2'h0);
		chk(d[3], 1'b0);
		st_wait(bpsw_pkg::BPSW_NORMAL);
		{temp_warning, temp_shutdown} <= 2'h3;
		st_wait(bpsw_pkg::BPSW_RESET);
		cyc(20);
		st_wait(bpsw_pkg::BPSW_RESET);
		chk({fixed_converter_en, adjustable_converter_en, host_reset_n}, 3'h0);
		rd(`BPSW_OFS_ASTAT, d, 2'h0);
		chk(d[0], 1'b1);
		rd(`BPSW_OFS_ASTAT, d, 2'h0);
		chk(d[0], 1'b1);
		off;
		{temp_warning, temp_shutdown} <= 2'h0;
		cyc(6);
		rd(`BPSW_OFS_ASTAT, d, 2'h0);
		chk(d[0], 1'b1);
		rd(`BPSW_OFS_ASTAT, d, 2'h0);
		chk(d[0], 1'b0);
		up;
	endtask

	task automatic t_sleep;
		wake_current_select <= 1'b0;
		cyc(4);
		wr(`BPSW_OFS_CTRL, 32'h1, 2'h0);
		cyc(10);
		st_wait(bpsw_pkg::BPSW_NORMAL);
		wake_current_select <= 1'b1;
		cyc(4);
		wr(`BPSW_OFS_CTRL, 32'h1, 2'h0);
		st_wait(bpsw_pkg::BPSW_SLEEP);
		off;
		cyc(10);
		st_wait(bpsw_pkg::BPSW_SLEEP);
		wake_current_select <= 1'b0;
		cyc(4);
		wake_current_select <= 1'b1;
		st_wait(bpsw_pkg::BPSW_RESET);
		rd(`BPSW_OFS_ASTAT, d, 2'h0);
		chk(d[1], 1'b1);
		up;
	endtask

	task automatic t_wdog;
		int e, f, k;
		f = reset_falls;
		cyc(200);
		chk(reset_falls, f);
		for (k = 0; k < 16; k++)
		begin
			e = early[k] * MS;
			f = reset_falls;
			wr(`BPSW_OFS_CTRL, {24'h0, 4'(k), 4'h2}, 2'h0);
			cyc(e);
			wr(`BPSW_OFS_CTRL, {24'h0, 4'(k), 4'h2}, 2'h0);
			cyc(2);
			chk(reset_falls, f);
			cyc(e - 8);
			wr(`BPSW_OFS_CTRL, {24'h0, 4'(k), 4'h2}, 2'h0);
			cyc(4);
			chk(reset_falls, f + 1);
			cyc(MS + 4);
		end
		for (k = 0; k < 2; k++)
		begin
			f = reset_falls;
			wr(`BPSW_OFS_CTRL, {24'h0, 4'(k), 4'h2}, 2'h0);
			cyc(33 * (k + 1) * MS - 10);
			chk(reset_falls, f);
			cyc(20);
			chk(reset_falls, f + 1);
			cyc(MS + 4);
		end
		wr(`BPSW_OFS_CTRL, 32'h0, 2'h0);
	endtask

	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, temp_warning, temp_shutdown} = '0;
		{fail_count, checks_done} = '0;
		off;
		{wake_current_select, osc_ok} = 2'h3;
		cyc(16);
		aresetn <= 1'b1;
		rd(`BPSW_OFS_CTRL, d, 2'h0);
		chk(d, 32'h0);
		st_wait(bpsw_pkg::BPSW_RESET);
		chk({host_reset_n, save_warning_n}, 2'h0);
		rd(4'hC, d, `BPSW_RESP_SLVERR);
		wr(`BPSW_OFS_STATUS, 32'h1, `BPSW_RESP_SLVERR);
		up;
		t_standby;
		t_therm;
		t_sleep;
		t_wdog;
		filter_above_14v <= 1'b0;
		cyc(6);
		chk({save_warning_n, host_reset_n}, 2'h1);
		off;
		cyc(6);
		chk({host_reset_n, adjustable_converter_en, fixed_converter_en}, 3'h0);
		st_wait(bpsw_pkg::BPSW_RESET);
		print_verdict;
	end

	initial
	begin
		cyc(60000);
		fail_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
